/* host_model.sv */
// Host platform model issuing byte cycles into the event block
`timescale 1ns/100ps
module host_model #(
    parameter logic [15:0] BASE = 16'h0308
) (
    input wire logic sys_clk_i,
    input wire logic [7:0] host_rdata_i,
    output logic [15:0] host_base_o,
    output logic [15:0] host_addr_o,
    output logic host_wr_o,
    output logic host_rd_o,
    output logic [7:0] host_wdata_o
);
    initial begin
        host_base_o = BASE;
        host_addr_o = 16'hfff0;
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        host_wdata_o = 8'h00;
    end
    // Idle bus shows the inverse of the last cycle so stale values never match
    task automatic cycle(input logic wr, input logic [15:0] addr, input logic [7:0] data);
        @(posedge sys_clk_i);
        host_addr_o <= addr;
        host_wdata_o <= data;
        host_wr_o <= wr;
        host_rd_o <= !wr;
        @(posedge sys_clk_i);
        host_wr_o <= 1'b0;
        host_rd_o <= 1'b0;
        host_addr_o <= ~addr;
        host_wdata_o <= ~data;
    endtask : cycle
    task automatic write(input logic [15:0] off, input logic [7:0] data);
        cycle(1'b1, BASE + off, data);
    endtask : write
    task automatic read(input logic [15:0] off, output logic [7:0] data);
        cycle(1'b0, BASE + off, 8'h00);
        @(negedge sys_clk_i);
        data = host_rdata_i;
    endtask : read
endmodule : host_model

/* pm_event_block.sv */
// Power management fixed event registers with host and controller ports
//
// Behaviour
// - Only button, override, alarm, wake and sleep bits
// - Host event line doubles as wake signal
// - Power button has status and enable
// - Controller writes status, reads enables only
// - Host one clears status, zero keeps
// - Controller can clear any status bit
// - Power button status and enable raise event
// - Override has own status and enable
// - Override enable is control high bit one
// - Controller sets sleep button status
// - Sleep or alarm with enable raise event
// - Controller sets alarm status on alarm
// - Enabled alarm can wake a sleeping system
// - Host reaches offsets zero to seven
// - Controller reaches fixed base plus offset
// - Active low line when enabled status set
// - Host writes pulse three controller interrupts
// - Controller writes one sets, zero clears
// - Reset returns everything to defaults
`timescale 1ns/100ps
module pm_event_block (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [15:0] host_base_i,
    input wire logic [15:0] host_addr_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    input wire logic [15:0] ec_addr_i,
    input wire logic ec_wr_i,
    input wire logic ec_rd_i,
    input wire logic [7:0] ec_wdata_i,
    output logic [7:0] ec_rdata_o,
    output logic host_event_irq_n_o,
    output logic status_write_irq_o,
    output logic enable_write_irq_o,
    output logic control_write_irq_o,
    output logic [2:0] sleep_type_o,
    output logic sleep_enable_o
);
    // True when an address falls in the eight byte block at the given base
    function automatic logic block_hit(input logic [15:0] addr, input logic [15:0] base);
        block_hit = (addr[15:3] == base[15:3]);
    endfunction : block_hit

    // Register byte selected by an offset
    function automatic logic [7:0] read_mux(input logic [2:0] off, input logic [7:0] sts,
                                            input logic [7:0] en, input logic [7:0] ctl,
                                            input logic [7:0] p2l, input logic [7:0] p2h);
        case (off)
            pm_event_pkg::OFF_STATUS_HIGH: read_mux = sts;
            pm_event_pkg::OFF_ENABLE_HIGH: read_mux = en;
            pm_event_pkg::OFF_CONTROL_HIGH: read_mux = ctl;
            pm_event_pkg::OFF_PM2_LOW: read_mux = p2l;
            pm_event_pkg::OFF_PM2_HIGH: read_mux = p2h;
            default: read_mux = 8'h00;
        endcase
    endfunction : read_mux

    logic host_hit;
    logic ec_hit;
    logic [2:0] host_off;
    logic [2:0] ec_off;
    logic host_sts_wr;
    logic ec_sts_wr;
    logic [7:0] status;
    logic [7:0] enable;
    logic [7:0] control;
    logic [7:0] pm2_low;
    logic [7:0] pm2_high;
    logic [7:0] next_enable;
    logic [7:0] next_control;
    logic [7:0] next_pm2_low;
    logic [7:0] next_pm2_high;
    logic [7:0] host_rdata;
    logic [7:0] ec_rdata;
    logic [7:0] next_host_rdata;
    logic [7:0] next_ec_rdata;
    logic irq_n;
    logic next_irq_n;
    logic sts_irq;
    logic en_irq;
    logic ctl_irq;
    logic next_sts_irq;
    logic next_en_irq;
    logic next_ctl_irq;
    logic event_any;

    // Host uses its configured base, the controller a fixed base
    assign host_hit = block_hit(host_addr_i, host_base_i);
    assign ec_hit = block_hit(ec_addr_i, pm_event_pkg::EC_BASE_ADDR);
    assign host_off = host_addr_i[2:0];
    assign ec_off = ec_addr_i[2:0];
    assign host_sts_wr = host_wr_i && host_hit && (host_off == pm_event_pkg::OFF_STATUS_HIGH);
    assign ec_sts_wr = ec_wr_i && ec_hit && (ec_off == pm_event_pkg::OFF_STATUS_HIGH);

    // Status byte: controller sets or clears, host writes one to clear
    pm_status_flags u_flags (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .ec_write_i(ec_sts_wr),
        .ec_data_i(ec_wdata_i),
        .host_clear_i(host_sts_wr),
        .host_data_i(host_wdata_i),
        .mask_i(pm_event_pkg::STATUS_MASK),
        .flags_o(status)
    );

    // Host owned enable, control and second control bytes
    always_comb begin
        next_enable = enable;
        next_control = control;
        next_pm2_low = pm2_low;
        next_pm2_high = pm2_high;
        if (host_wr_i && host_hit) begin
            case (host_off)
                pm_event_pkg::OFF_ENABLE_HIGH: begin
                    next_enable = host_wdata_i & pm_event_pkg::ENABLE_MASK;
                end
                pm_event_pkg::OFF_CONTROL_HIGH: begin
                    next_control = host_wdata_i & pm_event_pkg::CONTROL_MASK;
                end
                pm_event_pkg::OFF_PM2_LOW: begin
                    next_pm2_low = host_wdata_i & pm_event_pkg::PM2_MASK;
                end
                pm_event_pkg::OFF_PM2_HIGH: begin
                    next_pm2_high = host_wdata_i & pm_event_pkg::PM2_MASK;
                end
                default: begin
                    next_enable = enable;
                end
            endcase
        end
        // Controller writes to these bytes are ignored
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            enable <= pm_event_pkg::ENABLE_RESET;
            control <= pm_event_pkg::CONTROL_RESET;
            pm2_low <= pm_event_pkg::PM2_RESET;
            pm2_high <= pm_event_pkg::PM2_RESET;
        end else begin
            enable <= next_enable;
            control <= next_control;
            pm2_low <= next_pm2_low;
            pm2_high <= next_pm2_high;
        end
    end

    // Read data for both ports, returned the cycle after the strobe
    always_comb begin
        next_host_rdata = host_rdata;
        next_ec_rdata = ec_rdata;
        if (host_rd_i) begin
            next_host_rdata = host_hit ? read_mux(host_off, status, enable, control,
                                                  pm2_low, pm2_high) : 8'h00;
        end
        if (ec_rd_i) begin
            next_ec_rdata = ec_hit ? read_mux(ec_off, status, enable, control,
                                              pm2_low, pm2_high) : 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            host_rdata <= pm_event_pkg::READ_RESET;
            ec_rdata <= pm_event_pkg::READ_RESET;
        end else begin
            host_rdata <= next_host_rdata;
            ec_rdata <= next_ec_rdata;
        end
    end

    // Any enabled event, override gated by its own control bit
    assign event_any = |(status & enable & pm_event_pkg::EVENT_MASK)
        || (status[pm_event_pkg::BIT_POWER_OVERRIDE]
            && control[pm_event_pkg::BIT_OVERRIDE_ENABLE]);

    // Event line and controller write notifications
    always_comb begin
        next_irq_n = !event_any;
        next_sts_irq = host_sts_wr;
        next_en_irq = host_wr_i && host_hit && (host_off == pm_event_pkg::OFF_ENABLE_HIGH);
        next_ctl_irq = host_wr_i && host_hit && (host_off == pm_event_pkg::OFF_CONTROL_HIGH);
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            irq_n <= 1'b1;
            sts_irq <= 1'b0;
            en_irq <= 1'b0;
            ctl_irq <= 1'b0;
        end else begin
            irq_n <= next_irq_n;
            sts_irq <= next_sts_irq;
            en_irq <= next_en_irq;
            ctl_irq <= next_ctl_irq;
        end
    end

    assign host_rdata_o = host_rdata;
    assign ec_rdata_o = ec_rdata;
    assign host_event_irq_n_o = irq_n;
    assign status_write_irq_o = sts_irq;
    assign enable_write_irq_o = en_irq;
    assign control_write_irq_o = ctl_irq;
    assign sleep_type_o = control[pm_event_pkg::BIT_SLEEP_TYPE_MSB:pm_event_pkg::BIT_SLEEP_TYPE_LSB];
    assign sleep_enable_o = control[pm_event_pkg::BIT_SLEEP_ENABLE];

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    logic host_en_wr;
    logic host_ctl_wr;
    logic ec_en_wr;
    assign host_en_wr = host_wr_i && host_hit && (host_off == pm_event_pkg::OFF_ENABLE_HIGH);
    assign host_ctl_wr = host_wr_i && host_hit && (host_off == pm_event_pkg::OFF_CONTROL_HIGH);
    assign ec_en_wr = ec_wr_i && ec_hit && (ec_off == pm_event_pkg::OFF_ENABLE_HIGH);
    logic ec_ctl_wr;
    logic ec_pm2_wr;
    logic host_any_wr;
    assign ec_ctl_wr = ec_wr_i && ec_hit && (ec_off == pm_event_pkg::OFF_CONTROL_HIGH);
    assign ec_pm2_wr = ec_wr_i && ec_hit && (ec_off == pm_event_pkg::OFF_PM2_LOW
                                             || ec_off == pm_event_pkg::OFF_PM2_HIGH);
    assign host_any_wr = host_wr_i && host_hit;

    sequence s_pulse_once(sig);
        ##1 sig ##1 !sig;
    endsequence

    sequence s_ctl_written;
        host_ctl_wr && !$past(host_ctl_wr);
    endsequence

    a_irq_assert: assert property (
        (|(status & enable & pm_event_pkg::EVENT_MASK)) |=> !host_event_irq_n_o)
        else $error("event line not asserted for enabled status");

    a_irq_release: assert property (
        !event_any |=> host_event_irq_n_o)
        else $error("event line held after last enabled status cleared");

    a_override_irq: assert property (
        (status[pm_event_pkg::BIT_POWER_OVERRIDE] && control[pm_event_pkg::BIT_OVERRIDE_ENABLE])
        |=> !host_event_irq_n_o)
        else $error("override event did not assert the event line");

    a_host_clear: assert property (
        (host_sts_wr && !ec_sts_wr) |=> ((status & $past(host_wdata_i)) == 8'h00))
        else $error("host write of one did not clear status");

    a_host_zero_keep: assert property (
        (host_sts_wr && !ec_sts_wr && host_wdata_i == 8'h00) |=> $stable(status))
        else $error("host write of zero changed status");

    a_ec_write: assert property (
        ec_sts_wr |=> (status == ($past(ec_wdata_i) & pm_event_pkg::STATUS_MASK)))
        else $error("controller write did not set status as written");

    a_set_wins: assert property (
        (ec_sts_wr && host_sts_wr
         && (ec_wdata_i & host_wdata_i & pm_event_pkg::STATUS_MASK) != 8'h00)
        |=> ((status & $past(host_wdata_i)) != 8'h00))
        else $error("host clear beat a controller set");

    a_enable_ro: assert property (
        (ec_en_wr && !host_en_wr) |=> $stable(enable))
        else $error("controller write changed an enable");

    a_ctl_pulse: assert property (
        s_ctl_written ##1 !host_ctl_wr |-> ##0 control_write_irq_o ##1 !control_write_irq_o)
        else $error("control write notification not a single pulse");

    a_sts_pulse: assert property (
        (host_sts_wr ##1 !host_sts_wr) |-> ##0 status_write_irq_o ##1 !status_write_irq_o)
        else $error("status write notification wrong");

    a_en_pulse: assert property (
        host_en_wr |-> s_pulse_once(enable_write_irq_o) or ##1 (enable_write_irq_o && host_en_wr))
        else $error("enable write notification missing");

    a_host_read: assert property (
        (host_rd_i && host_hit && host_off == pm_event_pkg::OFF_ENABLE_HIGH)
        |=> host_rdata_o == $past(enable))
        else $error("host read of enable returned wrong data");

    a_reset_clear: assert property (@(posedge sys_clk_i)
        disable iff (1'b0)
        sys_rst_i |=> (status == 8'h00 && enable == 8'h00 && host_event_irq_n_o))
        else $error("reset did not return defaults");

    a_ec_ctl_ro: assert property (
        (ec_ctl_wr && !host_ctl_wr) |=> $stable(control))
        else $error("controller write changed the control byte");

    a_pm2_ro: assert property (
        (ec_pm2_wr && !host_any_wr) |=> ($stable(pm2_low) && $stable(pm2_high)))
        else $error("controller write changed a second control byte");

    a_enable_write: assert property (
        host_en_wr |=> (enable == ($past(host_wdata_i) & pm_event_pkg::ENABLE_MASK)))
        else $error("host enable write not stored");

    a_override_bit: assert property (
        host_ctl_wr |=> (control == ($past(host_wdata_i) & pm_event_pkg::CONTROL_MASK)))
        else $error("host control write not stored");

    a_status_reserved: assert property (
        (status & ~pm_event_pkg::STATUS_MASK) == 8'h00)
        else $error("reserved status bit set");

    a_enable_reserved: assert property (
        (enable & ~pm_event_pkg::ENABLE_MASK) == 8'h00)
        else $error("reserved enable bit set");

    a_ec_read: assert property (
        (ec_rd_i && ec_hit && ec_off == pm_event_pkg::OFF_STATUS_HIGH)
        |=> ec_rdata_o == $past(status))
        else $error("controller read of status returned wrong data");

    a_miss_read: assert property (
        (host_rd_i && !host_hit) |=> host_rdata_o == 8'h00)
        else $error("host read outside the block returned data");

    a_sleep_out: assert property (
        host_ctl_wr
        |=> (sleep_enable_o == $past(host_wdata_i[pm_event_pkg::BIT_SLEEP_ENABLE])))
        else $error("sleep enable output does not follow the control write");

    a_no_sts_pulse: assert property (
        !host_sts_wr |=> !status_write_irq_o)
        else $error("status write notification without a host write");

    a_no_en_pulse: assert property (
        !host_en_wr |=> !enable_write_irq_o)
        else $error("enable write notification without a host write");

    a_ec_miss: assert property (
        (ec_wr_i && !ec_hit && !host_sts_wr) |=> $stable(status))
        else $error("controller write outside the block changed status");
endmodule : pm_event_block

/* pm_event_pkg.sv */
// Constants for the power management fixed event register block
package pm_event_pkg;
    // Register offsets within the eight byte block
    localparam logic [2:0] OFF_STATUS_LOW = 3'h0;
    localparam logic [2:0] OFF_STATUS_HIGH = 3'h1;
    localparam logic [2:0] OFF_ENABLE_LOW = 3'h2;
    localparam logic [2:0] OFF_ENABLE_HIGH = 3'h3;
    localparam logic [2:0] OFF_CONTROL_LOW = 3'h4;
    localparam logic [2:0] OFF_CONTROL_HIGH = 3'h5;
    localparam logic [2:0] OFF_PM2_LOW = 3'h6;
    localparam logic [2:0] OFF_PM2_HIGH = 3'h7;
    // Status high field positions
    localparam int BIT_POWER_BUTTON = 0;
    localparam int BIT_SLEEP_BUTTON = 1;
    localparam int BIT_ALARM_EVENT = 2;
    localparam int BIT_POWER_OVERRIDE = 3;
    localparam int BIT_WAKE = 7;
    // Control high field positions
    localparam int BIT_OVERRIDE_ENABLE = 1;
    localparam int BIT_SLEEP_TYPE_LSB = 2;
    localparam int BIT_SLEEP_TYPE_MSB = 4;
    localparam int BIT_SLEEP_ENABLE = 5;
    // Implemented bits of each register
    localparam logic [7:0] STATUS_MASK = 8'h8f;
    localparam logic [7:0] ENABLE_MASK = 8'h07;
    localparam logic [7:0] CONTROL_MASK = 8'h3e;
    localparam logic [7:0] PM2_MASK = 8'hff;
    // Status bits that drive the host event line through the enable register
    localparam logic [7:0] EVENT_MASK = 8'h07;
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PM2_RESET = 8'h00;
    localparam logic [7:0] READ_RESET = 8'h00;
    // Block base seen by the embedded controller, arbitrary value
    localparam logic [15:0] EC_BASE_ADDR = 16'h0a00;
    localparam int ADDR_W = 16;
endpackage : pm_event_pkg

/* pm_status_flags.sv */
// Event status flags written by the controller and cleared by the host
`timescale 1ns/100ps
module pm_status_flags (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ec_write_i,
    input wire logic [7:0] ec_data_i,
    input wire logic host_clear_i,
    input wire logic [7:0] host_data_i,
    input wire logic [7:0] mask_i,
    output logic [7:0] flags_o
);
    logic [7:0] flags;
    logic [7:0] next_flags;

    always_comb begin
        next_flags = flags;
        if (host_clear_i) begin
            next_flags = next_flags & ~host_data_i;
        end
        // Controller write applied last so its set beats a host clear
        if (ec_write_i) begin
            next_flags = ec_data_i;
        end
        next_flags = next_flags & mask_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            flags <= pm_event_pkg::STATUS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    assign flags_o = flags;
endmodule : pm_status_flags

/* testbench.sv */
// Self-checking bench for the power management event register block
`timescale 1ns/100ps
`define CHK(name, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", name, exp, got); end end
module testbench;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [15:0] host_base, host_addr, ec_addr_i = 16'hfff0;
    logic host_wr, host_rd, ec_wr_i = 1'b0, ec_rd_i = 1'b0;
    logic [7:0] host_wdata, host_rdata, ec_wdata_i = 8'h00, ec_rdata;
    logic irq_n, sts_irq, en_irq, ctl_irq, sleep_en;
    logic [2:0] sleep_type;
    logic [7:0] d;
    int err_count = 0;
    int tests_run = 0;
    pm_event_block dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .host_base_i(host_base), .host_addr_i(host_addr), .host_wr_i(host_wr),
        .host_rd_i(host_rd), .host_wdata_i(host_wdata), .host_rdata_o(host_rdata),
        .ec_addr_i(ec_addr_i), .ec_wr_i(ec_wr_i), .ec_rd_i(ec_rd_i),
        .ec_wdata_i(ec_wdata_i), .ec_rdata_o(ec_rdata), .host_event_irq_n_o(irq_n),
        .status_write_irq_o(sts_irq), .enable_write_irq_o(en_irq),
        .control_write_irq_o(ctl_irq), .sleep_type_o(sleep_type),
        .sleep_enable_o(sleep_en));
    host_model host_u (.sys_clk_i(sys_clk_i), .host_rdata_i(host_rdata),
        .host_base_o(host_base), .host_addr_o(host_addr), .host_wr_o(host_wr),
        .host_rd_o(host_rd), .host_wdata_o(host_wdata));
    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    task automatic ec_cycle(input logic wr, input logic [15:0] off, input logic [7:0] data);
        @(posedge sys_clk_i);
        ec_addr_i <= pm_event_pkg::EC_BASE_ADDR + off;
        ec_wdata_i <= data;
        ec_wr_i <= wr;
        ec_rd_i <= !wr;
        @(posedge sys_clk_i);
        ec_wr_i <= 1'b0;
        ec_rd_i <= 1'b0;
        ec_addr_i <= ~(pm_event_pkg::EC_BASE_ADDR + off);
        ec_wdata_i <= ~data;
    endtask : ec_cycle
    task automatic ec_expect(input logic [15:0] off, input logic [7:0] exp);
        ec_cycle(1'b0, off, 8'h00);
        @(negedge sys_clk_i);
        `CHK("ec read", exp, ec_rdata)
    endtask : ec_expect
    task automatic host_expect(input logic [15:0] off, input logic [7:0] exp);
        host_u.read(off, d);
        `CHK("host read", exp, d)
    endtask : host_expect
    task automatic irq_after(input int n, input logic exp);
        repeat (n) @(negedge sys_clk_i);
        `CHK("event line", exp, irq_n)
    endtask : irq_after
    task automatic t_reset();
        for (int o = 0; o < 8; o++) host_expect(o[15:0], 8'h00);
        ec_expect(16'h0001, 8'h00);
        `CHK("idle event line", 1'b1, irq_n)
    endtask : t_reset
    task automatic t_enable();
        host_u.write(16'h0003, 8'hff);
        @(negedge sys_clk_i);
        `CHK("enable pulse", 1'b1, en_irq)
        @(negedge sys_clk_i);
        `CHK("enable pulse end", 1'b0, en_irq)
        host_expect(16'h0003, 8'h07);
        host_u.write(16'h0002, 8'hff);
        host_expect(16'h0002, 8'h00);
        ec_cycle(1'b1, 16'h0003, 8'h00);
        ec_expect(16'h0003, 8'h07);
        host_u.write(16'h0006, 8'ha5);
        host_u.write(16'h0007, 8'h5a);
        ec_cycle(1'b1, 16'h0007, 8'h00);
        host_expect(16'h0006, 8'ha5);
        ec_expect(16'h0007, 8'h5a);
    endtask : t_enable
    task automatic t_events();
        for (int b = 0; b < 3; b++) begin
            ec_cycle(1'b1, 16'h0001, 8'h01 << b);
            irq_after(1, 1'b1);
            irq_after(1, 1'b0);
            host_u.write(16'h0001, ~(8'h01 << b));
            @(negedge sys_clk_i);
            `CHK("status pulse", 1'b1, sts_irq)
            host_expect(16'h0001, 8'h01 << b);
            host_u.write(16'h0001, 8'h01 << b);
            irq_after(1, 1'b0);
            irq_after(1, 1'b1);
        end
    endtask : t_events
    task automatic t_override();
        host_u.write(16'h0005, 8'hff);
        @(negedge sys_clk_i);
        `CHK("control pulse", 1'b1, ctl_irq)
        `CHK("sleep type", 3'h7, sleep_type)
        `CHK("sleep enable", 1'b1, sleep_en)
        ec_cycle(1'b1, 16'h0005, 8'h00);
        host_expect(16'h0005, 8'h3e);
        ec_cycle(1'b1, 16'h0001, 8'h08);
        irq_after(2, 1'b0);
        host_u.write(16'h0005, 8'h3c);
        irq_after(2, 1'b1);
        ec_cycle(1'b1, 16'h0001, 8'h00);
        host_expect(16'h0001, 8'h00);
    endtask : t_override
    task automatic t_ec_side();
        ec_cycle(1'b1, 16'h0001, 8'hff);
        ec_expect(16'h0001, 8'h8f);
        ec_cycle(1'b1, 16'h0001, 8'h80);
        host_u.write(16'h0001, 8'h00);
        host_expect(16'h0001, 8'h80);
        fork
            host_u.write(16'h0001, 8'h81);
            ec_cycle(1'b1, 16'h0001, 8'h01);
        join
        host_expect(16'h0001, 8'h01);
        ec_cycle(1'b1, 16'h0009, 8'h00);
        host_u.write(16'h0009, 8'h01);
        host_expect(16'h0001, 8'h01);
        host_expect(16'h0008, 8'h00);
    endtask : t_ec_side
    task automatic t_reset_mid();
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        host_expect(16'h0001, 8'h00);
        host_expect(16'h0003, 8'h00);
        host_expect(16'h0005, 8'h00);
    endtask : t_reset_mid
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_enable();
        t_events();
        t_override();
        t_ec_side();
        t_reset_mid();
        finish_test();
    end
    initial begin
        #(40 * 3000);
        err_count++;
        finish_test();
    end
endmodule : testbench
